//--- rtl/dplc_pkg.sv
// Purpose: shared constants for the dual pixel link configuration block
// Assumes: classic Wishbone register access, 32-bit data, byte addresses
// Notes: lane width mode codes follow the strap levels low, mid and high
package dplc_pkg;
    localparam int PIX_W = 24;                      // one pixel of 24-bit colour
    localparam int PAIR_W = 48;                     // two pixels, dual pixel word
    localparam int ADR_W = 8;
    localparam int MAX_PIX_MHZ = 112;               // highest pixel clock supported
    // register byte addresses
    localparam logic [ADR_W-1:0] CTRL_ADR = 8'h00;
    localparam logic [ADR_W-1:0] STAT_ADR = 8'h04;
    // control register layout
    localparam int CTRL_W = 5;
    localparam int MODE_LSB = 0;
    localparam int EDGE_BIT = 2;
    localparam int POL_BIT = 3;
    localparam int PDN_BIT = 4;
    // single mode, rising edge strobe, active high flag, powered down
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h0C;
    // status register layout
    localparam int STAT_W = 4;
    localparam int ST_PLL_BIT = 0;
    localparam int ST_PHASE_BIT = 1;
    localparam int ST_ACT_BIT = 2;
    localparam int ST_HI_BIT = 3;
    // lane width modes
    typedef enum logic [1:0] {
        DPLC_SINGLE = 2'h0,
        DPLC_SPLIT = 2'h1,
        DPLC_DUAL = 2'h2
    } dplc_mode_type;
endpackage : dplc_pkg

//--- rtl/dplc_sync3.sv
// Purpose: three flop synchroniser for slow static levels
// Assumes: input may change at any time relative to clk_i
// Notes: output takes a new value only once stages two and three agree
`timescale 1ns/10ps
module dplc_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] q_ff;
    // first stage is seen only by the second stage
    always_ff @(posedge clk_i) begin
        s1_ff <= d_i;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end
    // filter: a bit moves only when two settled stages agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    q_ff[g] <= 1'b0;
                end else if (s2_ff[g] == s3_ff[g]) begin
                    q_ff[g] <= s3_ff[g];
                end
            end
        end
    endgenerate
    assign q_o = q_ff;
endmodule : dplc_sync3

//--- rtl/dplc_link.sv
// Purpose: pixel link transmitter lane mapping, receiver output gating, register access
// Assumes: clk_i is the bus clock, pix_clk_i the pixel clock, unrelated in phase
// Notes: control bits are static straps in practice, so each bit crosses on its own
`timescale 1ns/10ps
module dplc_link
    import dplc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // transmitter parallel side
    input wire logic pix_clk_i,
    input wire logic [PIX_W-1:0] pix_first_i,
    input wire logic [PIX_W-1:0] pix_second_i,
    input wire logic active_video_flag_i,
    // transmitter serial side
    output logic [PIX_W-1:0] serial_data_lane_lo_o,
    output logic [PIX_W-1:0] serial_data_lane_hi_o,
    output logic serial_data_lane_lo_oe_o,
    output logic serial_data_lane_hi_oe_o,
    output logic link_active_o,
    output logic link_word_o,
    output logic serial_clock_o,
    output logic serial_clock_oe_o,
    output logic second_serial_clock_o,
    output logic second_serial_clock_oe_o,
    output logic pll_run_o,
    // receiver side
    input wire logic [PAIR_W-1:0] rx_lane_i,
    input wire logic rx_flag_i,
    output logic [PAIR_W-1:0] rx_pix_o,
    output logic rx_active_o,
    output logic rx_clk_o
);
    // ---------------- bus clock domain ----------------
    logic [CTRL_W-1:0] ctrl_ff;
    logic [CTRL_W-1:0] nxt_ctrl;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [STAT_W-1:0] stat_s;
    // address decode
    wire req_w = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire hit_ctrl_w = (wb_adr_i[ADR_W-1:2] == CTRL_ADR[ADR_W-1:2]);
    wire hit_stat_w = (wb_adr_i[ADR_W-1:2] == STAT_ADR[ADR_W-1:2]);
    // write lands at the edge where the master samples ack, so both sides agree on it
    wire wr_ctrl_w = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & hit_ctrl_w & wb_sel_i[0];
    // control byte lives in byte lane 0; unmapped reads return zero
    assign nxt_ctrl = wr_ctrl_w ? wb_dat_i[CTRL_W-1:0] : ctrl_ff;
    wire [31:0] rsel_w = hit_ctrl_w ? {{(32-CTRL_W){1'b0}}, ctrl_ff} :
                         hit_stat_w ? {{(32-STAT_W){1'b0}}, stat_s} : 32'h0000_0000;

    // control register resets powered down until software releases it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // one wait state answer; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req_w;
            rdat_ff <= req_w ? rsel_w : rdat_ff;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held for more than one cycle");

    // ---------------- pixel clock domain ----------------
    logic pix_rst;
    logic [CTRL_W-1:0] ctrl_s;
    logic [STAT_W-1:0] stat_ff;
    // reset and control levels cross with three flops each
    dplc_sync3 #(.WIDTH(1)) u_rst_sync (
        .clk_i(pix_clk_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(pix_rst)
    );
    dplc_sync3 #(.WIDTH(CTRL_W)) u_ctrl_sync (
        .clk_i(pix_clk_i),
        .rst_i(pix_rst),
        .d_i(ctrl_ff),
        .q_o(ctrl_s)
    );
    // status returns to the bus domain the same way
    dplc_sync3 #(.WIDTH(STAT_W)) u_stat_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(stat_ff),
        .q_o(stat_s)
    );

    // control fields as seen by the pixel logic
    wire [1:0] mode_raw_w = ctrl_s[MODE_LSB +: 2];
    wire edge_rise_w = ctrl_s[EDGE_BIT];
    wire pol_high_w = ctrl_s[POL_BIT];
    wire pdn_w = ctrl_s[PDN_BIT];
    // the reserved code behaves as single mode
    wire is_split_w = (mode_raw_w == DPLC_SPLIT);
    wire is_dual_w = (mode_raw_w == DPLC_DUAL);
    wire is_single_w = ~is_split_w & ~is_dual_w;

    // input strobes on both edges; the select picks one, the other is ignored
    logic [PIX_W-1:0] rise_a_ff;
    logic [PIX_W-1:0] rise_b_ff;
    logic rise_de_ff;
    logic [PIX_W-1:0] fall_a_ff;
    logic [PIX_W-1:0] fall_b_ff;
    logic fall_de_ff;
    always_ff @(posedge pix_clk_i) begin
        rise_a_ff <= pix_first_i;
        rise_b_ff <= pix_second_i;
        rise_de_ff <= active_video_flag_i;
    end
    always_ff @(negedge pix_clk_i) begin
        fall_a_ff <= pix_first_i;
        fall_b_ff <= pix_second_i;
        fall_de_ff <= active_video_flag_i;
    end
    wire [PIX_W-1:0] smp_a_w = edge_rise_w ? rise_a_ff : fall_a_ff;
    wire [PIX_W-1:0] smp_b_w = edge_rise_w ? rise_b_ff : fall_b_ff;
    wire smp_de_w = edge_rise_w ? rise_de_ff : fall_de_ff;

    // retime into one stage; frozen while powered down to cut toggling
    logic [PIX_W-1:0] cap_a_ff;
    logic [PIX_W-1:0] cap_b_ff;
    logic cap_de_ff;
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            cap_a_ff <= 24'h00_0000;
            cap_b_ff <= 24'h00_0000;
            cap_de_ff <= 1'b0;
        end else if (pdn_w) begin
            cap_a_ff <= smp_a_w;
            cap_b_ff <= smp_b_w;
            cap_de_ff <= smp_de_w;
        end
    end

    // active data by polarity; split mode restarts pairing where it rises
    wire act_w = pol_high_w ? cap_de_ff : ~cap_de_ff;
    logic act_prev_ff;
    wire start_w = act_w & ~act_prev_ff;

    // pairing state: phase high means the odd pixel is held
    logic phase_ff;
    logic [PIX_W-1:0] odd_ff;
    wire emit_pair_w = is_split_w & phase_ff & ~start_w;
    // blanking keeps toggling the phase, so an even count keeps pairs aligned
    wire nxt_phase = is_split_w & (start_w | ~phase_ff);
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst | ~pdn_w) begin
            act_prev_ff <= 1'b0;
            phase_ff <= 1'b0;
            odd_ff <= 24'h00_0000;
        end else begin
            act_prev_ff <= act_w;
            phase_ff <= nxt_phase;
            odd_ff <= nxt_phase ? cap_a_ff : odd_ff;
        end
    end

    // lane content per mode
    wire word_w = is_split_w ? emit_pair_w : 1'b1;
    wire [PIX_W-1:0] nxt_lo = is_split_w ? odd_ff : cap_a_ff;
    wire [PIX_W-1:0] nxt_hi = is_split_w ? cap_a_ff :
                              is_dual_w ? cap_b_ff : 24'h00_0000;
    wire hi_on_w = pdn_w & ~is_single_w;

    logic [PIX_W-1:0] lo_ff;
    logic [PIX_W-1:0] hi_ff;
    logic lo_oe_ff;
    logic hi_oe_ff;
    logic link_act_ff;
    logic word_ff;
    logic sclk_ff;
    logic sclk2_ff;
    logic sclk2_oe_ff;
    logic pll_ff;
    // serial side: one word per pixel, or one per pair in split mode
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst | ~pdn_w) begin
            lo_ff <= 24'h00_0000;
            hi_ff <= 24'h00_0000;
            link_act_ff <= 1'b0;
            word_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sclk2_ff <= 1'b0;
        end else if (word_w) begin
            lo_ff <= nxt_lo;
            hi_ff <= hi_on_w ? nxt_hi : 24'h00_0000;
            link_act_ff <= act_w;
            word_ff <= 1'b1;
            sclk_ff <= ~sclk_ff;
            sclk2_ff <= hi_on_w ? ~sclk_ff : 1'b0;
        end else begin
            word_ff <= 1'b0;
        end
    end

    // drivers released and multiplier stopped while powered down
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            lo_oe_ff <= 1'b0;
            hi_oe_ff <= 1'b0;
            sclk2_oe_ff <= 1'b0;
            pll_ff <= 1'b0;
        end else begin
            lo_oe_ff <= pdn_w;
            hi_oe_ff <= hi_on_w;
            sclk2_oe_ff <= hi_on_w;
            pll_ff <= pdn_w;
        end
    end

    assign serial_data_lane_lo_o = lo_ff;
    assign serial_data_lane_hi_o = hi_ff;
    assign serial_data_lane_lo_oe_o = lo_oe_ff;
    assign serial_data_lane_hi_oe_o = hi_oe_ff;
    assign link_active_o = link_act_ff;
    assign link_word_o = word_ff;
    assign serial_clock_o = sclk_ff;
    assign serial_clock_oe_o = lo_oe_ff;
    assign second_serial_clock_o = sclk2_ff;
    assign second_serial_clock_oe_o = sclk2_oe_ff;
    assign pll_run_o = pll_ff;

    // receiver: one registered stage, fits a full pair each pixel clock
    logic [PAIR_W-1:0] rx_pix_ff;
    logic rx_act_ff;
    logic rx_clk_ff;
    wire rx_act_w = pol_high_w ? rx_flag_i : ~rx_flag_i;
    // single links carry nothing on the high half
    wire [PAIR_W-1:0] rx_mask_w = is_single_w ? {{PIX_W{1'b0}}, {PIX_W{1'b1}}} : {PAIR_W{1'b1}};
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst | ~pdn_w) begin
            rx_pix_ff <= 48'h0000_0000_0000;
            rx_act_ff <= 1'b0;
            rx_clk_ff <= 1'b1;
        end else begin
            rx_pix_ff <= rx_lane_i & rx_mask_w;
            rx_act_ff <= rx_act_w;
            rx_clk_ff <= ~rx_clk_ff;
        end
    end
    assign rx_pix_o = rx_pix_ff;
    assign rx_active_o = rx_act_ff;
    assign rx_clk_o = rx_clk_ff;

    // status snapshot for software
    always_ff @(posedge pix_clk_i) begin
        if (pix_rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff[ST_PLL_BIT] <= pll_ff;
            stat_ff[ST_PHASE_BIT] <= phase_ff;
            stat_ff[ST_ACT_BIT] <= act_w;
            stat_ff[ST_HI_BIT] <= hi_oe_ff;
        end
    end

    // ---------------- checks ----------------
    a_pd_release: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        !pdn_w |=> !serial_data_lane_lo_oe_o && !serial_data_lane_hi_oe_o
                    && !second_serial_clock_oe_o && !pll_run_o)
        else $error("serial drivers active during power down");

    a_single_hi_off: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        is_single_w |=> !serial_data_lane_hi_oe_o && serial_data_lane_hi_o == 24'h00_0000)
        else $error("high lanes active in single mode");

    a_dual_clk_twin: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (is_dual_w && pdn_w) [*2] |=> second_serial_clock_o == serial_clock_o)
        else $error("second serial clock differs in dual mode");

    a_split_start: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (is_split_w && pdn_w && start_w) |=> phase_ff && odd_ff == $past(cap_a_ff))
        else $error("pairing did not restart on active flag");

    a_split_pair: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (pdn_w && emit_pair_w) |=> link_word_o && serial_data_lane_lo_o == $past(odd_ff)
                    && serial_data_lane_hi_o == $past(cap_a_ff))
        else $error("split pair not placed on low then high lanes");

    a_split_half: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (is_split_w && pdn_w && link_word_o) |=> !link_word_o)
        else $error("split mode word rate above half pixel rate");

    a_dual_width: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (is_dual_w && pdn_w) |=> serial_data_lane_hi_o == $past(cap_b_ff)
                    && serial_data_lane_lo_o == $past(cap_a_ff))
        else $error("dual pixel word not taken whole");

    a_rx_pd_hold: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        !pdn_w |=> rx_pix_o == 48'h0000_0000_0000 && rx_clk_o && !rx_active_o)
        else $error("receiver outputs not parked in power down");

    a_capture_edge: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (pdn_w && !edge_rise_w) |=> cap_a_ff == $past(fall_a_ff))
        else $error("falling edge select not honoured");

    a_flag_polarity: assert property (@(posedge pix_clk_i) disable iff (pix_rst)
        (pdn_w && !pol_high_w) |=> rx_active_o == !$past(rx_flag_i))
        else $error("active flag polarity not applied");
endmodule : dplc_link

//--- verification/dplc_src_model.sv
// Purpose: pixel source model standing on the transmitter's parallel side
// Assumes: pixel value is a running count, each frame is 4 blank then 8 active cycles
// Notes: blanking is even, so split pairing never slips between frames
`timescale 1ns/10ps
module dplc_src_model
    import dplc_pkg::*;
(
    input wire logic pix_clk_i,
    input wire logic rst_i,
    input wire logic flag_high_i,
    output logic [PIX_W-1:0] pix_first_o,
    output logic [PIX_W-1:0] pix_second_o,
    output logic active_video_flag_o
);
    logic [PIX_W-1:0] cnt_ff;
    logic act;
    // count runs every pixel clock, so the value names its own frame phase
    always_ff @(posedge pix_clk_i) begin
        cnt_ff <= rst_i ? 24'h0 : cnt_ff + 24'h1;
    end
    // visible part of the frame, 4 blank cycles keep the blanking even
    assign act = (cnt_ff % 24'hC) >= 24'h4;
    assign pix_first_o = cnt_ff;
    assign pix_second_o = ~cnt_ff; // complement makes pair swaps visible
    assign active_video_flag_o = flag_high_i ? act : ~act;
endmodule : dplc_src_model

//--- verification/tb_dual_pixel_lvds_link_config.sv
// Purpose: self-checking bench for the pixel link configuration block
// Assumes: control bits are changed only while the stream checks are idle
// Notes: stream checks run at the pixel falling edge, where outputs are settled
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module tb_dual_pixel_lvds_link_config
    import dplc_pkg::*;
;
    logic clk_i = 1'b0, pix_clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed;
    logic wb_ack_o, flag_high = 1'b1, rx_flag_i = 1'b0, prev_word = 1'b0, prev_sclk = 1'b0;
    logic [PIX_W-1:0] pix_first_i, pix_second_i, lo, hi, prev_lo;
    logic [PAIR_W-1:0] rx_lane_i = 48'h0, rx_pix_o;
    logic active_video_flag_i, lo_oe, hi_oe, link_active_o, link_word_o, sclk, sclk_oe;
    logic sclk2, sclk2_oe, pll_run_o, rx_active_o, rx_clk_o;
    int n_errors = 0, cmp_count = 0, chk = 0, cyc_n = 0;
    logic [3:0] cfg [7] = '{4'h3, 4'h1, 4'hA, 4'h9, 4'h7, 4'h5, 4'hF};

    always #20 clk_i = ~clk_i;
    always #16 pix_clk_i = ~pix_clk_i;

    dplc_link dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_clk_i(pix_clk_i),
        .pix_first_i(pix_first_i), .pix_second_i(pix_second_i),
        .active_video_flag_i(active_video_flag_i), .serial_data_lane_lo_o(lo),
        .serial_data_lane_hi_o(hi), .serial_data_lane_lo_oe_o(lo_oe),
        .serial_data_lane_hi_oe_o(hi_oe), .link_active_o(link_active_o),
        .link_word_o(link_word_o), .serial_clock_o(sclk), .serial_clock_oe_o(sclk_oe),
        .second_serial_clock_o(sclk2), .second_serial_clock_oe_o(sclk2_oe),
        .pll_run_o(pll_run_o), .rx_lane_i(rx_lane_i), .rx_flag_i(rx_flag_i),
        .rx_pix_o(rx_pix_o), .rx_active_o(rx_active_o), .rx_clk_o(rx_clk_o));

    dplc_src_model src_u (.pix_clk_i(pix_clk_i), .rst_i(rst_i), .flag_high_i(flag_high),
        .pix_first_o(pix_first_i), .pix_second_o(pix_second_i),
        .active_video_flag_o(active_video_flag_i));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic is_act(input logic [PIX_W-1:0] v);
        return (v % 24'hC) >= 24'h4;
    endfunction : is_act

    task print_verdict;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // one classic cycle: request held until ack is sampled high
    task wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        `CHK(n < 50, 1'b1, "no ack")
    endtask : wb_xfer

    // random receiver pairs, given time to pass the single registered receiver stage
    // em 4 means powered down: data and flag parked low whatever the lanes carry
    task rx_chk(input logic pol, input int em);
        logic [PAIR_W-1:0] exp_pix;
        repeat (4) begin
            seed = lfsr(seed);
            @(posedge pix_clk_i);
            rx_lane_i <= {seed[23:0], seed[31:8]};
            rx_flag_i <= seed[0];
            repeat (4) @(negedge pix_clk_i);
            exp_pix = em == 4 ? 48'h0 : (em == 1 ? {24'h0, rx_lane_i[23:0]} : rx_lane_i);
            `CHK(rx_pix_o, exp_pix, "rx data")
            `CHK(rx_active_o, em != 4 && (rx_flag_i ~^ pol), "rx flag")
        end
    endtask : rx_chk

    // stream checks on every serial word; chk 1 single, 2 split, 3 dual, 4 powered down
    always @(negedge pix_clk_i) begin
        if (chk == 4) begin
            `CHK(pll_run_o, 1'b0, "pll runs")
            `CHK({lo_oe, hi_oe, sclk_oe, sclk2_oe}, 4'h0, "driven")
            `CHK(rx_pix_o, 48'h0, "rx not low")
            `CHK(rx_clk_o, 1'b1, "rx clock")
        end else if (chk != 0 && link_word_o === 1'b1) begin
            `CHK(link_active_o, is_act(lo), "flag")
            `CHK({lo_oe, sclk_oe, pll_run_o, hi_oe}, {3'h7, chk != 1}, "drivers")
            if (chk == 1) `CHK({hi, hi_oe, sclk2_oe}, 26'h0, "high lanes on")
            if (chk == 3) `CHK({hi, sclk2, sclk2_oe}, {~lo, sclk, 1'b1}, "dual")
            if (chk != 2 && prev_word) `CHK(lo, prev_lo + 24'h1, "order")
            if (chk == 2 && link_active_o) `CHK({lo[0], hi}, {1'b0, lo + 24'h1}, "pair")
        end
        if (chk == 2) `CHK(link_word_o & prev_word, 1'b0, "word rate")
        // the serial clock moves with each word and stands still between words
        if (chk != 0 && chk != 4) `CHK(sclk ^ prev_sclk, link_word_o, "clock toggle")
        prev_word = link_word_o;
        prev_lo = lo;
        prev_sclk = sclk;
    end

    // hang guard, far above the fewer than a thousand cycles the sequence needs
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_errors++;
            print_verdict;
        end
    end

    initial begin
        seed = 32'h75E1D610;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, CTRL_ADR, 32'h0);
        `CHK(rd, {27'h0, CTRL_RST}, "ctrl reset")
        wb_xfer(1'b1, 8'h40, 32'h1F);
        wb_xfer(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0, "unmapped read")
        chk = 4;
        rx_chk(1'b1, 4);
        chk = 0;
        foreach (cfg[i]) begin
            flag_high <= cfg[i][0];
            wb_xfer(1'b1, CTRL_ADR, {27'h0, 1'b1, cfg[i][0], cfg[i][1], cfg[i][3:2]});
            repeat (60) @(posedge clk_i);
            wb_xfer(1'b0, CTRL_ADR, 32'h0);
            `CHK(rd, {27'h0, 1'b1, cfg[i][0], cfg[i][1], cfg[i][3:2]}, "ctrl readback")
            wb_xfer(1'b0, STAT_ADR, 32'h0);
            `CHK({rd[3], rd[0]}, {cfg[i][3] ^ cfg[i][2], 1'b1}, "status")
            chk = cfg[i][3:2] == 2'h1 ? 2 : (cfg[i][3:2] == 2'h2 ? 3 : 1);
            rx_chk(cfg[i][0], chk);
            repeat (40) @(posedge pix_clk_i);
            chk = 0;
        end
        wb_xfer(1'b1, CTRL_ADR, 32'h0E);
        repeat (40) @(posedge clk_i);
        chk = 4;
        repeat (30) @(posedge pix_clk_i);
        chk = 0;
        print_verdict;
    end
endmodule : tb_dual_pixel_lvds_link_config
